// *** verilog/tpio_top.v ***
`timescale 1ns/1ps
`include "tpio_defines.vh"
module tpio_top
(
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // converter channel select
   input wire [4:0] converter_channel_select,
   // first port pins
   input wire [7:0] first_port_in,
   output wire [7:0] first_port_out,
   output wire [7:0] first_port_oe_n,
   // analog-shared port pins
   input wire [7:0] analog_port_in,
   output wire [7:0] analog_port_out,
   output wire [7:0] analog_port_oe_n,
   // six-pin port pins
   input wire [5:0] six_pin_port_in,
   output wire [5:0] six_pin_port_out,
   output wire [5:0] six_pin_port_oe_n
);
   reg [7:0] first_port_latch;
   reg [7:0] analog_port_latch;
   reg [5:0] six_pin_port_latch;
   reg [7:0] first_port_dir;
   reg [7:0] analog_port_dir;
   reg [5:0] six_pin_port_dir;
   reg clock_out_enable;
   reg [7:0] rdata_nxt;
   wire [21:0] pins_s;
   wire [7:0] first_pin_s;
   wire [7:0] analog_pin_s;
   wire [5:0] six_pin_s;
   wire [7:0] conv_sel;
   wire pin2_dir_bit;

   // one-hot of the converter channel currently selected on port pins
   function [7:0] chan_hot;
      input [4:0] ch;
      begin
         chan_hot = 8'h00;
         if (ch[4:3] == 2'b00)
            chan_hot[ch[2:0]] = 1'b1;
      end
   endfunction

   // per-bit choice between latch and pin
   function [7:0] mux_read;
      input [7:0] dir;
      input [7:0] latch;
      input [7:0] pin;
      begin
         mux_read = (dir & latch) | (~dir & pin);
      end
   endfunction

   tpio_sync u_sync
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .d_in({six_pin_port_in, analog_port_in, first_port_in}),
      .q_out(pins_s)
   );
   assign first_pin_s = pins_s[7:0];
   assign analog_pin_s = pins_s[15:8];
   assign six_pin_s = pins_s[21:16];
   assign conv_sel = chan_hot(converter_channel_select);
   assign pin2_dir_bit = six_pin_port_dir[`TPIO_CLKOUT_PIN];

   // latches hold through reset
   always @(posedge clk_sys)
   begin
      if (reg_wr)
      begin
         case (reg_addr)
            `TPIO_OFS_A_DATA: first_port_latch <= reg_wdata;
            `TPIO_OFS_B_DATA: analog_port_latch <= reg_wdata;
            `TPIO_OFS_C_DATA: six_pin_port_latch <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         first_port_dir <= `TPIO_DIR_RESET;
         analog_port_dir <= `TPIO_DIR_RESET;
         six_pin_port_dir <= `TPIO_C_DIR_RESET;
         clock_out_enable <= 1'b0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `TPIO_OFS_A_DIR: first_port_dir <= reg_wdata;
            `TPIO_OFS_B_DIR: analog_port_dir <= reg_wdata;
            `TPIO_OFS_C_DIR:
            begin
               six_pin_port_dir <= reg_wdata[5:0];
               clock_out_enable <= reg_wdata[`TPIO_CLKOUT_BIT];
            end
            default: ;
         endcase
      end
   end

   always @*
   begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `TPIO_OFS_A_DATA:
            rdata_nxt = mux_read(first_port_dir, first_port_latch,
               first_pin_s);
         `TPIO_OFS_B_DATA:
            rdata_nxt = mux_read(analog_port_dir, analog_port_latch,
               analog_pin_s & ~conv_sel);
         `TPIO_OFS_C_DATA:
            rdata_nxt = mux_read({2'b00, six_pin_port_dir},
               {2'b00, six_pin_port_latch}, {2'b00, six_pin_s});
         `TPIO_OFS_A_DIR: rdata_nxt = first_port_dir;
         `TPIO_OFS_B_DIR: rdata_nxt = analog_port_dir;
         `TPIO_OFS_C_DIR:
            rdata_nxt = {clock_out_enable, 1'b0, six_pin_port_dir};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= 8'h00;
   end

   assign first_port_out = first_port_latch;
   assign first_port_oe_n = ~first_port_dir;
   assign analog_port_out = analog_port_latch;
   // converter-owned pins float regardless of direction
   assign analog_port_oe_n = ~(analog_port_dir & ~conv_sel);
   assign six_pin_port_out = clock_out_enable ?
      {six_pin_port_latch[5:3], clk_sys, six_pin_port_latch[1:0]} :
      six_pin_port_latch;
   assign six_pin_port_oe_n = ~({six_pin_port_dir[5:3],
      pin2_dir_bit | clock_out_enable, six_pin_port_dir[1:0]});
endmodule // tpio_top

// *** verilog/tpio_defines.vh ***
// How it works
// - latches writable; reset leaves latches alone
// - direction one drives pin, zero floats
// - reset clears all direction bits
// - read gives latch if output, else pin
// - data writes always update the latch
// - analog port uses the same read choice
// - converter-selected input pin reads zero
// - converter pins ignore direction for buffer
// - six-pin port keeps bits five to zero
// - direction bit seven drives clock on pin2
// - clock-out overrides pin2 direction bit
// - unimplemented six-pin bits read zero
`ifndef TPIO_DEFINES_VH
`define TPIO_DEFINES_VH
`define TPIO_ADDR_W 4
`define TPIO_OFS_A_DATA 4'h0
`define TPIO_OFS_B_DATA 4'h1
`define TPIO_OFS_C_DATA 4'h2
`define TPIO_OFS_A_DIR 4'h4
`define TPIO_OFS_B_DIR 4'h5
`define TPIO_OFS_C_DIR 4'h6
`define TPIO_DIR_RESET 8'h00
`define TPIO_C_DIR_RESET 6'h00
`define TPIO_CLKOUT_BIT 7
`define TPIO_CLKOUT_PIN 2
`define TPIO_CH_W 5
`endif

// *** verilog/tpio_sync.v ***
`timescale 1ns/1ps
module tpio_sync
(
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // asynchronous level in, synchronised level out
   input wire [21:0] d_in,
   output reg [21:0] q_out
);
   reg [21:0] meta_r;
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         meta_r <= 22'h0;
         q_out <= 22'h0;
      end
      else
      begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // tpio_sync

// *** sim/tpio_pins.sv ***
`timescale 1ns/1ps
module tpio_pins
(
   // pin drive in, pin level out
   input wire [21:0] drv,
   input wire [21:0] oe_n,
   input wire [21:0] ext,
   output wire [21:0] lvl
);
   // a floating pin shows the outside source
   assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule // tpio_pins

// *** sim/tpio_monitor.sv ***
`timescale 1ns/1ps
module tpio_monitor
(
   // watched ports
   input wire clk_sys,
   input wire nrst,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [4:0] converter_channel_select,
   input wire [7:0] first_port_out,
   input wire [7:0] first_port_oe_n,
   input wire [7:0] analog_port_oe_n,
   input wire [5:0] six_pin_port_out,
   input wire [5:0] six_pin_port_oe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   AST_RD_IDLE:
      assert property (!$past(reg_rd) |-> !reg_rdata) else $error("idle");
   AST_RST_IN:
      assert property (disable iff (1'h0) !nrst |=>
      &{first_port_oe_n, analog_port_oe_n, six_pin_port_oe_n})
      else $error("rst");
   AST_A_DIR:
      assert property (reg_wr && reg_addr == 4'h4 |=>
      first_port_oe_n == ~$past(reg_wdata)) else $error("dir");
   AST_A_LAT:
      assert property (reg_wr && reg_addr == 4'h0 |=>
      first_port_out == $past(reg_wdata)) else $error("lat");
   AST_C_LAT:
      assert property (reg_wr && reg_addr == 4'h2 |=> ((six_pin_port_out ^
      $past(reg_wdata[5:0])) & 6'h3B) == 6'h00) else $error("c lat");
   AST_CLK_OUT:
      assert property (reg_wr && reg_addr == 4'h6 && reg_wdata[7] |=>
      !six_pin_port_oe_n[2]) else $error("clk out");
   AST_CONV:
      assert property (converter_channel_select < 5'h08 && $stable(
      converter_channel_select) |-> analog_port_oe_n[converter_channel_select
      [2:0]]) else $error("conv");
   AST_A_RD:
      assert property (reg_rd && reg_addr == 4'h0 && !first_port_oe_n |=>
      reg_rdata == $past(first_port_out)) else $error("rd");
   cover property (reg_wr ##1 reg_rd);
   cover property (reg_rd && converter_channel_select < 5'h08);
   cover property (reg_rd && !six_pin_port_oe_n[2]);
endmodule // tpio_monitor
bind tpio_top tpio_monitor mon (.*);

// *** sim/tpio_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("mismatch %0t %h %h", $time, g, e); end end
module tpio_top_tb;
   reg clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
   reg [3:0] reg_addr = 0, p;
   reg [7:0] reg_wdata = 0, lat, dir;
   reg [4:0] sel = 5'h1F;
   reg [21:0] ext = 0;
   reg [15:0] seed = 16'hA39F;
   wire [7:0] reg_rdata, ao, aoe, bo, boe;
   wire [5:0] co, coe;
   wire [21:0] lvl;
   wire [15:0] pv = p == 0 ? {ao, aoe} : p == 1 ? {bo, boe} :
      {2'h0, co, 2'h0, coe};
   integer n_mismatch = 0, checks = 0, i;
   tpio_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .converter_channel_select(sel),
      .first_port_in(lvl[21:14]), .first_port_out(ao), .first_port_oe_n(aoe),
      .analog_port_in(lvl[13:6]), .analog_port_out(bo), .analog_port_oe_n(boe),
      .six_pin_port_in(lvl[5:0]), .six_pin_port_out(co),
      .six_pin_port_oe_n(coe));
   tpio_pins far (.drv({ao, bo, co}), .oe_n({aoe, boe, coe}), .ext(ext),
      .lvl(lvl));
   function [15:0] nx(input [15:0] s);
      nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [7:0] ex(input [3:0] q, input [7:0] d, l, input [21:0] x,
      input [4:0] s);
      begin
         ex = q == 0 ? x[21:14] : q == 1 ? x[13:6] : {2'h0, x[5:0]};
         ex = (d & l) | (~d & ex);
         // converter-selected input reads zero
         if (q == 1 && s < 8) ex[s[2:0]] = d[s[2:0]] & l[s[2:0]];
      end
   endfunction
   // pin drive and active-low enables; converter-selected pin floats
   function [15:0] po(input [3:0] q, input [7:0] d, l, input [4:0] s);
      begin
         po = {l, ~(d & ~((q == 1 && s < 8) ? 8'h01 << s[2:0] : 8'h00))};
         if (q == 2) po = {2'h0, l[5:0], 2'h0, ~d[5:0]};
      end
   endfunction
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'h1;
         @(posedge clk_sys);
         reg_wr <= 1'h0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd <= 1'h1;
         @(posedge clk_sys);
         reg_rd <= 1'h0;
         #1 `CHK(reg_rdata, e)
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial forever #5 clk_sys = ~clk_sys;
   initial
   begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'h1;
      wr(4'h0, 8'hA5);
      wr(4'h6, 8'hFF);
      nrst <= 1'h0;
      @(posedge clk_sys);
      nrst <= 1'h1;
      rd(4'h6, 8'h00);
      wr(4'h4, 8'hFF);
      rd(4'h0, 8'hA5);
      wr(4'h6, 8'hFF);
      rd(4'h6, 8'hBF);
      `CHK({coe[2], co[2]}, 2'h1)
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      for (i = 0; i < 90; i++)
      begin
         p = 4'(i % 3);
         seed = nx(seed);
         lat = seed[7:0];
         dir = seed[15:8] & (p == 2 ? 8'h3F : 8'hFF);
         seed = nx(seed);
         @(posedge clk_sys);
         ext <= {seed[5:0], seed};
         sel <= {1'h0, seed[11:8]};
         wr(p, lat);
         wr(p + 4'h4, dir);
         repeat (2) @(posedge clk_sys);
         rd(p, ex(p, dir, lat, ext, sel));
         rd(p + 4'h4, dir);
         `CHK(pv, po(p, dir, lat, sel))
      end
      finish_test;
   end
endmodule // tpio_top_tb
